//--- src/etp_timer.sv
/*
 8-bit timer/counter with one compare channel, four wave modes,
 prescaler and external count pin, flags and interrupt requests.
 All state sits in one packed struct, registered in one process.
 Assumes an Avalon-MM master on clock, an interrupt controller giving
 global enable and vector acknowledges, and a port mux for the pin.
 Every bus access takes exactly one wait cycle; only byte lane 0 counts.
 The count pin is asynchronous and passes three flip-flops; a pin edge
 moves the counter about three clocks later, whatever the pin direction.
 The prescaler runs free from reset, so the first divided tick after a
 clock select write may come anywhere within one prescaler period.
 A forced match takes its action from the control value being written.
 Set events win over clears; requests are plain levels, no vector logic.
 Count writes block only the next tick's match, wave action and clear-on-match wrap.
 Phase mode turns at max and at zero, each value seen once per pass.

// Summary of operation
// R01: Force strobe acts only in non-PWM modes; ignored in PWM modes.
// R02: Software writes force bit zero while a PWM mode runs.
// R03: Force strobe applies match action now using current action field.
// R04: Force strobe sets no flag, no interrupt, never clears counter.
// R05: Force bit always reads back as zero.
// R06: Mode 0 normal, 1 phase PWM, 2 clear-on-match, 3 fast PWM.
// R07: Match update immediate/top/bottom; overflow at max or bottom.
// R08: Nonzero action field overrides port; direction bit enables driver.
// R09: Non-PWM actions: off, toggle, clear, set on match.
// R10: Fast PWM: off, reserved, clear-match/set-bottom, set-match/clear-bottom.
// R11: Fast PWM with match at top ignores match, acts at bottom only.
// R12: Phase PWM: 10 clears up, sets down; 11 reverse; 01 reserved.
// R13: Phase PWM with match at top ignores match, acts at top.
// R14: Clock select: stop, undivided, /8, /64, /256, /1024.
// R15: Select 6 counts falling, 7 rising external pin edges.
// R16: External edges count even when pin is an output.
// R17: Counter read/write; write blocks match on next tick.
// R18: Match register compared with counter continuously.
// R19: Match request when match enable, global enable, match flag set.
// R20: Overflow request when overflow enable, global enable, flag set.
// R21: Match flag set on match; cleared by vector or write one.
// R22: Flag bits 7..2 read zero; flags reset to zero.
// R23: Overflow flag set on overflow or phase turn at zero.
// R24: Control layout: 7 force, 6 mode low, 5:4 action, 3 mode high, 2:0 clock.
// R25: External pin synchronised and edge detected before counting.
// R26: Separate vector acknowledges clear match and overflow flags.
// R27: Flag set wins over same-cycle clear.
*/
`default_nettype none
module etp_timer (
    input wire logic clock, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [7:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    input wire logic countPin, // External count pin level
    input wire logic globalIrqEn, // Global interrupt enable
    input wire logic matchAck, // Match vector taken
    input wire logic ovfAck, // Overflow vector taken
    input wire logic portData, // Normal port output value
    input wire logic portDir, // Pin direction, 1 = output
    output logic pinOut, // Pin output value
    output logic pinOe, // Pin output enable
    output logic matchIrq, // Match interrupt request
    output logic ovfIrq // Overflow interrupt request
);
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] cnt;
        logic [7:0] ocr;
        logic [7:0] ocrBuf;
        logic [1:0] mask;
        logic [1:0] flags;
        logic down;
        logic wave;
        logic block;
        logic [9:0] presc;
        logic [2:0] sync;
        logic done;
        logic [7:0] rdata;
    } etp_state_t;

    etp_state_t s_r;
    etp_state_t s_nxt;

    logic [1:0] mode;
    logic [1:0] com;
    logic [2:0] cs;
    logic busReq;
    logic wrEn;
    logic [7:0] wd;
    logic hitFlags;
    logic hitCtrl;
    logic hitCount;
    logic hitMatch;
    logic hitMask;
    logic [7:0] rdMux;
    logic extRise;
    logic extFall;
    logic tick;
    logic [7:0] top;
    logic isMatch;
    logic matchEv;
    logic pwmIgnore;
    logic [3:0] tapHit;
    logic [1:0] irqVec;
    logic wrapNow;
    logic matchWave;
    logic forceWave;

    // Control fields
    assign mode = {s_r.ctl[etp_pkg::CTL_WHI], s_r.ctl[etp_pkg::CTL_WLO]};
    assign com = s_r.ctl[etp_pkg::CTL_COM_HI:etp_pkg::CTL_COM_LO];
    assign cs = s_r.ctl[etp_pkg::CTL_CS_HI:0];

    // Bus: one wait cycle, then the access completes
    assign busReq = read | write;
    assign waitrequest = busReq & ~s_r.done;
    assign wrEn = write & s_r.done & byteenable[0];
    assign wd = writedata[7:0];
    assign hitFlags = address == {etp_pkg::IDX_FLAGS, 2'b00};
    assign hitCtrl = address == {etp_pkg::IDX_CTRL, 2'b00};
    assign hitCount = address == {etp_pkg::IDX_COUNT, 2'b00};
    assign hitMatch = address == {etp_pkg::IDX_MATCH, 2'b00};
    assign hitMask = address == {etp_pkg::IDX_MASK, 2'b00};
    always_comb
    begin
        case (address)
            {etp_pkg::IDX_FLAGS, 2'b00}: rdMux = {6'h00, s_r.flags}; // R22
            {etp_pkg::IDX_CTRL, 2'b00}: rdMux = {1'b0, s_r.ctl[6:0]}; // R05
            {etp_pkg::IDX_COUNT, 2'b00}: rdMux = s_r.cnt; // R17
            {etp_pkg::IDX_MATCH, 2'b00}: rdMux = s_r.ocrBuf;
            {etp_pkg::IDX_MASK, 2'b00}: rdMux = {6'h00, s_r.mask};
            default: rdMux = 8'h00;
        endcase
    end
    assign readdata = {24'h000000, s_r.rdata};

    // Edge detect on 2nd and 3rd sync stages, pin direction ignored
    assign extRise = s_r.sync[1] & ~s_r.sync[2]; // R25 R16
    assign extFall = ~s_r.sync[1] & s_r.sync[2]; // R25 R16

    // Prescaler taps: one entry per divided rate, slowest last
    localparam logic [9:0] TAPS [4] = '{etp_pkg::TAP_DIV8, etp_pkg::TAP_DIV64,
        etp_pkg::TAP_DIV256, etp_pkg::TAP_DIV1024};
    for (genvar t = 0; t < 4; t++)
    begin : g_tap
        assign tapHit[t] = (s_r.presc & TAPS[t]) == TAPS[t]; // R14
    end

    always_comb
    begin
        unique case (cs)
            etp_pkg::CS_STOP: tick = 1'b0; // R14
            etp_pkg::CS_DIV1: tick = 1'b1; // R14
            etp_pkg::CS_DIV8: tick = tapHit[0]; // R14
            etp_pkg::CS_DIV64: tick = tapHit[1]; // R14
            etp_pkg::CS_DIV256: tick = tapHit[2]; // R14
            etp_pkg::CS_DIV1024: tick = tapHit[3]; // R14
            etp_pkg::CS_EXT_FALL: tick = extFall; // R15
            etp_pkg::CS_EXT_RISE: tick = extRise; // R15
        endcase
    end

    assign top = (mode == etp_pkg::MODE_CTC) ? s_r.ocr : etp_pkg::TOP_FIXED; // R06
    assign isMatch = s_r.cnt == s_r.ocr; // R18
    assign matchEv = tick & isMatch & ~s_r.block; // R17
    assign pwmIgnore = mode[0] & com[1] & (s_r.ocr == etp_pkg::TOP_FIXED); // R11 R13
    // A blocked match also skips the clear-on-match wrap
    assign wrapNow = (s_r.cnt == top) & ~((mode == etp_pkg::MODE_CTC) & s_r.block); // R17

    // Non-PWM actions for a counted match and for a forced match
    always_comb
    begin
        unique case (com) // R09
            etp_pkg::COM_OFF: matchWave = s_r.wave;
            etp_pkg::COM_TOGGLE: matchWave = ~s_r.wave;
            etp_pkg::COM_CLEAR: matchWave = 1'b0;
            etp_pkg::COM_SET: matchWave = 1'b1;
        endcase
        unique case (wd[etp_pkg::CTL_COM_HI:etp_pkg::CTL_COM_LO]) // R03
            etp_pkg::COM_OFF: forceWave = s_r.wave;
            etp_pkg::COM_TOGGLE: forceWave = ~s_r.wave;
            etp_pkg::COM_CLEAR: forceWave = 1'b0;
            etp_pkg::COM_SET: forceWave = 1'b1;
        endcase
    end

    // Next state; software writes come last and win over the count, except flag clears
    always_comb
    begin
        logic setO;
        logic setM;
        logic clrO;
        logic clrM;
        logic [1:0] setVec;
        logic [1:0] clrVec;
        setO = 1'b0;
        setM = 1'b0;
        clrO = 1'b0;
        clrM = 1'b0;
        setVec = 2'h0;
        clrVec = 2'h0;
        s_nxt = s_r;
        s_nxt.done = busReq & ~s_r.done;
        s_nxt.presc = s_r.presc + 10'h001;
        s_nxt.sync = {s_r.sync[1:0], countPin};
        if (busReq & ~s_r.done)
        begin
            s_nxt.rdata = rdMux;
        end
        if (tick)
        begin
            s_nxt.block = 1'b0;
            setM = isMatch & ~s_r.block; // R21
            unique case (mode)
                etp_pkg::MODE_NORMAL, etp_pkg::MODE_CTC:
                begin
                    if (wrapNow)
                    begin
                        s_nxt.cnt = etp_pkg::BOTTOM;
                    end
                    else
                    begin
                        s_nxt.cnt = s_r.cnt + 8'h01;
                    end
                    setO = s_r.cnt == etp_pkg::TOP_FIXED; // R07
                    if (matchEv)
                    begin
                        s_nxt.wave = matchWave; // R09
                    end
                end
                etp_pkg::MODE_FPWM:
                begin
                    // Match sets one level, the wrap to bottom the other
                    s_nxt.cnt = s_r.cnt + 8'h01;
                    if (matchEv & com[1] & ~pwmIgnore)
                    begin
                        s_nxt.wave = com[0]; // R10 R11
                    end
                    if (s_r.cnt == etp_pkg::TOP_FIXED)
                    begin
                        setO = 1'b1; // R07
                        s_nxt.ocr = s_r.ocrBuf; // R07
                        if (com[1])
                        begin
                            s_nxt.wave = ~com[0]; // R10 R11
                        end
                    end
                end
                etp_pkg::MODE_PCPWM:
                begin
                    // Up to max, turn, down to zero, turn
                    if (matchEv & com[1] & ~pwmIgnore)
                    begin
                        s_nxt.wave = s_r.down ? ~com[0] : com[0]; // R12
                    end
                    if (~s_r.down)
                    begin
                        if (s_r.cnt == etp_pkg::TOP_FIXED)
                        begin
                            s_nxt.down = 1'b1;
                            s_nxt.cnt = etp_pkg::TOP_TURN;
                            s_nxt.ocr = s_r.ocrBuf; // R07
                            if (pwmIgnore)
                            begin
                                s_nxt.wave = ~com[0]; // R13
                            end
                        end
                        else
                        begin
                            s_nxt.cnt = s_r.cnt + 8'h01;
                        end
                    end
                    else if (s_r.cnt == etp_pkg::BOTTOM)
                    begin
                        s_nxt.down = 1'b0;
                        s_nxt.cnt = etp_pkg::BOTTOM_TURN;
                        setO = 1'b1; // R23 R07
                    end
                    else
                    begin
                        s_nxt.cnt = s_r.cnt - 8'h01;
                    end
                end
            endcase
        end
        // Non-PWM modes use the buffered match value at once
        if (mode == etp_pkg::MODE_NORMAL || mode == etp_pkg::MODE_CTC)
        begin
            s_nxt.ocr = s_r.ocrBuf; // R07
            s_nxt.down = 1'b0;
        end
        if (wrEn & hitCtrl)
        begin
            s_nxt.ctl = {1'b0, wd[6:0]}; // R24 R05
            // Forced match: wave only, no flag, no counter clear
            if (wd[etp_pkg::CTL_FORCE] & ~wd[etp_pkg::CTL_WLO]) // R01 R04
            begin
                s_nxt.wave = forceWave; // R03
            end
        end
        // Blocks the match on the next tick only
        if (wrEn & hitCount)
        begin
            s_nxt.cnt = wd; // R17
            s_nxt.block = 1'b1; // R17
        end
        if (wrEn & hitMatch)
        begin
            s_nxt.ocrBuf = wd;
            if (~mode[0])
            begin
                s_nxt.ocr = wd; // R07
            end
        end
        if (wrEn & hitMask)
        begin
            s_nxt.mask = wd[1:0];
        end
        clrO = (wrEn & hitFlags & wd[etp_pkg::BIT_OVF]) | ovfAck; // R26
        clrM = (wrEn & hitFlags & wd[etp_pkg::BIT_MATCH]) | matchAck; // R26 R21
        setVec[etp_pkg::BIT_OVF] = setO; // R23
        setVec[etp_pkg::BIT_MATCH] = setM; // R21
        clrVec[etp_pkg::BIT_OVF] = clrO;
        clrVec[etp_pkg::BIT_MATCH] = clrM;
        // Set wins, so an event in the clearing cycle is kept
        for (int b = 0; b < 2; b++)
        begin
            s_nxt.flags[b] = (s_r.flags[b] & ~clrVec[b]) | setVec[b]; // R27
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        // Constants only in the reset branch
        if (!arst_n)
        begin
            s_r.ctl <= etp_pkg::CTRL_RST; // R24
            s_r.cnt <= etp_pkg::COUNT_RST;
            s_r.ocr <= etp_pkg::MATCH_RST;
            s_r.ocrBuf <= etp_pkg::MATCH_RST;
            s_r.mask <= etp_pkg::MASK_RST;
            s_r.flags <= etp_pkg::FLAGS_RST; // R22
            s_r.down <= 1'b0;
            s_r.wave <= 1'b0;
            s_r.block <= 1'b0;
            s_r.presc <= etp_pkg::PRESC_RST;
            s_r.sync <= 3'h0;
            s_r.done <= 1'b0;
            s_r.rdata <= 8'h00;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Pin mux: wave output takes the pin once any action bit is set
    assign pinOut = (|com) ? s_r.wave : portData; // R08
    assign pinOe = portDir; // R08

    // Request per flag bit
    for (genvar i = 0; i < 2; i++)
    begin : g_irq
        assign irqVec[i] = globalIrqEn & s_r.mask[i] & s_r.flags[i]; // R19 R20
    end
    assign matchIrq = irqVec[etp_pkg::BIT_MATCH]; // R19
    assign ovfIrq = irqVec[etp_pkg::BIT_OVF]; // R20
endmodule // etp_timer
`default_nettype wire

//--- common/etp_pkg.sv
/*
 Constants for the 8-bit timer/PWM block: register indices, field
 positions, reset values, mode and clock-select codes, prescaler taps.
 Assumes a 32-bit Avalon-MM slave with byte addresses = index * 4.
*/
`default_nettype none
package etp_pkg;
    // Register indices; byte address is index * 4
    localparam logic [5:0] IDX_FLAGS = 6'h15;
    localparam logic [5:0] IDX_CTRL = 6'h24;
    localparam logic [5:0] IDX_COUNT = 6'h26;
    localparam logic [5:0] IDX_MATCH = 6'h27;
    localparam logic [5:0] IDX_MASK = 6'h2e;
    // Control register fields
    localparam int CTL_FORCE = 7;
    localparam int CTL_WLO = 6;
    localparam int CTL_COM_HI = 5;
    localparam int CTL_COM_LO = 4;
    localparam int CTL_WHI = 3;
    localparam int CTL_CS_HI = 2;
    // Flag and mask bits
    localparam int BIT_OVF = 0;
    localparam int BIT_MATCH = 1;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] MATCH_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    // Wave modes {high bit, low bit}
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PCPWM = 2'h1;
    localparam logic [1:0] MODE_CTC = 2'h2;
    localparam logic [1:0] MODE_FPWM = 2'h3;
    // Match output actions
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    // Clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Counter limits
    localparam logic [7:0] TOP_FIXED = 8'hff;
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] TOP_TURN = 8'hfe;
    localparam logic [7:0] BOTTOM_TURN = 8'h01;
    // Prescaler taps: tick when masked low bits are all ones
    localparam logic [9:0] PRESC_RST = 10'h000;
    localparam logic [9:0] TAP_DIV8 = 10'h007;
    localparam logic [9:0] TAP_DIV64 = 10'h03f;
    localparam logic [9:0] TAP_DIV256 = 10'h0ff;
    localparam logic [9:0] TAP_DIV1024 = 10'h3ff;
endpackage
`default_nettype wire

//--- verif/etp_timer_assertions.sv
/*
 Concurrent checks on the ports of the 8-bit timer block.
 Bound to etp_timer from the bench top file; one clock domain.
*/
`default_nettype none
module etp_timer_assertions (
    input wire logic clock, // System clock
    input wire logic arst_n, // Async reset
    input wire logic [7:0] address, // Bus address
    input wire logic read, // Bus read
    input wire logic write, // Bus write
    input wire logic [31:0] readdata, // Bus read data
    input wire logic waitrequest, // Bus wait
    input wire logic globalIrqEn, // Global enable
    input wire logic matchAck, // Match vector taken
    input wire logic ovfAck, // Overflow vector taken
    input wire logic portDir, // Pin direction
    input wire logic pinOe, // Pin enable
    input wire logic matchIrq, // Match request
    input wire logic ovfIrq // Overflow request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_req;
        (read || write) && waitrequest;
    endsequence
    sequence s_rd_done;
        read && !waitrequest;
    endsequence
    a_wait_once: assert property (s_req |=> !waitrequest)
        else $error("waitrequest held past one cycle");
    a_wait_first: assert property (($rose(read) || $rose(write)) |-> waitrequest)
        else $error("request answered without a wait cycle");
    a_idle_ready: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest high while idle");
    a_flag_reserved: assert property (s_rd_done ##0 address == 8'h54 |-> readdata[7:2] == 6'h0)
        else $error("reserved flag bits read nonzero");
    a_force_reads: assert property (s_rd_done ##0 address == 8'h90 |-> !readdata[7])
        else $error("force bit read as one");
    a_oe_dir: assert property (pinOe == portDir)
        else $error("pin enable differs from direction");
    a_match_gate: assert property (!globalIrqEn |-> !matchIrq)
        else $error("match request without global enable");
    a_ovf_gate: assert property (!globalIrqEn |-> !ovfIrq)
        else $error("overflow request without global enable");
    a_match_hold: assert property (matchIrq && !matchAck && !write |=> matchIrq || !globalIrqEn)
        else $error("match request dropped without a clear");
    a_ovf_hold: assert property (ovfIrq && !ovfAck && !write |=> ovfIrq || !globalIrqEn)
        else $error("overflow request dropped without a clear");
endmodule // etp_timer_assertions
`default_nettype wire

//--- verif/etp_timer_bench.sv
/*
 Self-checking bench for the 8-bit timer block.
 Drives all ports directly; registers via Avalon-MM tasks.
*/
`default_nettype none
module etp_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_FLG = {etp_pkg::IDX_FLAGS, 2'b00};
    localparam logic [7:0] A_CTL = {etp_pkg::IDX_CTRL, 2'b00};
    localparam logic [7:0] A_CNT = {etp_pkg::IDX_COUNT, 2'b00};
    localparam logic [7:0] A_MAT = {etp_pkg::IDX_MATCH, 2'b00};
    localparam logic [7:0] A_MSK = {etp_pkg::IDX_MASK, 2'b00};
    logic clock = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, countPin = 1'b0;
    logic globalIrqEn = 1'b0, matchAck = 1'b0, ovfAck = 1'b0, portData = 1'b0, portDir = 1'b1;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata;
    logic [3:0] byteenable = 4'h1;
    logic waitrequest, pinOut, pinOe, matchIrq, ovfIrq;
    logic [7:0] q;
    int err_count = 0, num_checks = 0;
    etp_timer uut (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .countPin(countPin), .globalIrqEn(globalIrqEn),
        .matchAck(matchAck), .ovfAck(ovfAck), .portData(portData), .portDir(portDir),
        .pinOut(pinOut), .pinOe(pinOe), .matchIrq(matchIrq), .ovfIrq(ovfIrq));
    always #5 clock = ~clock;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        @(posedge clock);
        while (waitrequest) @(posedge clock);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        cmp(q, e);
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
    endtask
    task automatic t_reset();
        chk(A_FLG, 8'h00);
        chk(A_CTL, 8'h00);
        chk(A_CNT, 8'h00);
        chk(A_MAT, 8'h00);
        chk(A_MSK, 8'h00);
        chk(8'h00, 8'h00);
    endtask
    task automatic t_force();
        bus(1'b1, A_CTL, 8'hb0);
        settle();
        cmp(pinOut, 1'b1);
        chk(A_CTL, 8'h30);
        chk(A_FLG, 8'h00);
        bus(1'b1, A_CTL, 8'ha0);
        settle();
        cmp(pinOut, 1'b0);
        bus(1'b1, A_CTL, 8'h90);
        settle();
        cmp(pinOut, 1'b1);
        bus(1'b1, A_CTL, 8'he0);
        settle();
        cmp(pinOut, 1'b1);
        bus(1'b1, A_CTL, 8'h00);
        settle();
        cmp(pinOut, portData);
        portDir <= 1'b0;
        settle();
        cmp(pinOe, 1'b0);
        portDir <= 1'b1;
    endtask
    task automatic t_irq();
        bus(1'b1, A_MSK, 8'h03);
        bus(1'b1, A_MAT, 8'h05);
        bus(1'b1, A_CNT, 8'hf0);
        globalIrqEn <= 1'b1;
        bus(1'b1, A_CTL, 8'h01);
        repeat (40) @(posedge clock);
        bus(1'b1, A_CTL, 8'h00);
        chk(A_FLG, 8'h03);
        cmp({matchIrq, ovfIrq}, 2'b11);
        globalIrqEn <= 1'b0;
        settle();
        cmp({matchIrq, ovfIrq}, 2'b00);
        globalIrqEn <= 1'b1;
        @(posedge clock);
        matchAck <= 1'b1;
        @(posedge clock);
        matchAck <= 1'b0;
        settle();
        cmp({matchIrq, ovfIrq}, 2'b01);
        bus(1'b1, A_FLG, 8'h01);
        chk(A_FLG, 8'h00);
    endtask
    task automatic t_modes();
        bus(1'b1, A_MAT, 8'h10);
        bus(1'b1, A_CNT, 8'h10);
        bus(1'b1, A_CTL, 8'h01);
        repeat (10) @(posedge clock);
        bus(1'b1, A_CTL, 8'h00);
        chk(A_FLG, 8'h00);
        bus(1'b1, A_CNT, 8'h00);
        bus(1'b1, A_MAT, 8'h03);
        bus(1'b1, A_CTL, 8'h09);
        repeat (20) @(posedge clock);
        bus(1'b1, A_CTL, 8'h00);
        chk(A_FLG, 8'h02);
        bus(1'b0, A_CNT, 8'h00);
        cmp(q <= 8'h03, 1'b1);
    endtask
    task automatic t_clksel();
        int dv[5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, A_CNT, 8'h00);
            bus(1'b1, A_CTL, 8'(i + 1));
            repeat (4 * dv[i] - 3) @(posedge clock);
            bus(1'b1, A_CTL, 8'h00);
            bus(1'b0, A_CNT, 8'h00);
            cmp(q >= 8'h03 && q <= 8'h05, 1'b1);
        end
    endtask
    task automatic t_ext();
        for (int cs = 6; cs < 8; cs++)
        begin
            bus(1'b1, A_CNT, 8'h00);
            bus(1'b1, A_CTL, 8'(cs));
            repeat (3)
            begin
                countPin <= 1'b1;
                repeat (4) @(posedge clock);
                countPin <= 1'b0;
                repeat (4) @(posedge clock);
            end
            repeat (6) @(posedge clock);
            bus(1'b1, A_CTL, 8'h00);
            chk(A_CNT, 8'h03);
        end
    endtask
    task automatic t_pwm();
        bus(1'b1, A_MAT, 8'h80);
        bus(1'b1, A_CNT, 8'h70);
        bus(1'b1, A_CTL, 8'h69);
        repeat (30) @(posedge clock);
        bus(1'b1, A_CTL, 8'h68);
        bus(1'b0, A_CNT, 8'h00);
        cmp(pinOut, q < 8'h81);
        bus(1'b1, A_CTL, 8'ha0);
        bus(1'b1, A_CNT, 8'hf0);
        bus(1'b1, A_CTL, 8'h61);
        repeat (200) @(posedge clock);
        bus(1'b1, A_CTL, 8'h60);
        bus(1'b0, A_CNT, 8'h00);
        cmp(pinOut, q < 8'h80);
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_force();
        t_irq();
        t_modes();
        t_clksel();
        t_ext();
        t_pwm();
        print_verdict();
    end
    initial
    begin
        #300us;
        err_count++;
        print_verdict();
    end
endmodule // etp_timer_bench
bind etp_timer etp_timer_assertions chk (.clock(clock), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .globalIrqEn(globalIrqEn), .matchAck(matchAck), .ovfAck(ovfAck), .portDir(portDir),
    .pinOe(pinOe), .matchIrq(matchIrq), .ovfIrq(ovfIrq));
`default_nettype wire
